// File: common/bus_cycle_pkg.sv
// Contract
// - 16-bit unstack doubles on narrow external stack
// - misaligned unstack stretches unless memory supports it
// - vector fetch aligned, doubles narrow external program
// - slow chip select may stretch any cycle except a free one
// - byte conditional read: read or free, slow-stretch
// - word conditional read: doubles, misaligned stretch
// - byte conditional write: write or free, slow-stretch
// - short branch: three taken, one not
// - short not taken: advance, fetch one word
// - taken branch: compute target, three fetches
// - long branch: four taken, three not
// - prebyte optional cycle: fetch misaligned, free aligned
// - long not taken adds trailing optional cycle
// - program fetch aligned word, doubles narrow external
// - optional cycle turned free never stretched
package bus_cycle_pkg;
  typedef enum logic [3:0] {
    ACC_UNSTACK16  = 4'h0,
    ACC_VECTOR     = 4'h1,
    ACC_CREAD8     = 4'h2,
    ACC_CREAD16    = 4'h3,
    ACC_CWRITE8    = 4'h4,
    ACC_SHORT_BR   = 4'h5,
    ACC_LONG_BR    = 4'h6,
    ACC_PROG_FETCH = 4'h7
  } access_kind_t;

  typedef enum logic [2:0] {
    PH_IDLE   = 3'h0,
    PH_MEM    = 3'h1,
    PH_FREE   = 3'h2,
    PH_PREBYTE = 3'h4,
    PH_REFILL = 3'h5,
    PH_TRAIL  = 3'h6
  } phase_t;

  localparam logic [3:0] SLOW_EXTRA_DEFAULT = 4'h2;
  localparam logic [1:0] REFILL_FETCHES     = 2'h3;
endpackage : bus_cycle_pkg

// File: verilog/word_access_sizer.sv
`timescale 1ns/100ps
// number of bus cycles for one memory access
module word_access_sizer #(
  parameter int EXTRA_W = 4
) (
  input  wire logic               is_word_in,      // 16-bit access
  input  wire logic               narrow_ext_in,   // 8-bit bus and external target
  input  wire logic               misaligned_in,   // odd address word
  input  wire logic               mis_ok_in,       // target allows one-cycle misaligned
  input  wire logic               slow_cs_in,      // slow chip select range
  input  wire logic [EXTRA_W-1:0] slow_extra_in,   // extra slow-memory cycles
  output logic      [EXTRA_W+1:0] cycles_out       // total bus cycles
);
  always_comb
  begin
    cycles_out = (EXTRA_W+2)'(1);
    if (is_word_in && (narrow_ext_in || (misaligned_in && !mis_ok_in)))
    begin
      cycles_out = (EXTRA_W+2)'(2);
    end
    if (slow_cs_in)
    begin
      cycles_out = cycles_out + (EXTRA_W+2)'(slow_extra_in);
    end
  end
endmodule : word_access_sizer

// File: verilog/bus_cycle_seq.sv
`timescale 1ns/100ps
module bus_cycle_seq #(
  parameter int EXTRA_W = 4
) (
  input  wire logic                        sys_clk_in,      // 125 MHz clock
  input  wire logic                        rst_n_in,        // async reset, active low
  input  wire logic                        start_in,        // request pulse, taken when ready
  input  wire bus_cycle_pkg::access_kind_t kind_in,         // access kind
  input  wire logic [15:0]                 addr_in,         // data/stack/vector/prebyte address
  input  wire logic [15:0]                 target_in,       // branch destination
  input  wire logic                        do_access_in,    // conditional access performed
  input  wire logic                        taken_in,        // branch taken
  input  wire logic                        narrow_bus_in,   // 8-bit external data bus
  input  wire logic                        external_in,     // target in external memory
  input  wire logic                        mis_ok_in,       // memory allows one-cycle misaligned
  input  wire logic                        slow_cs_in,      // slow chip-select range
  input  wire logic [EXTRA_W-1:0]          slow_extra_in,   // slow extra cycles
  output logic                             ready_out,       // idle, can take request
  output logic                             done_out,        // one-cycle pulse in the first idle cycle after the sequence
  output logic                             rd_strobe_out,   // memory read strobe
  output logic                             wr_strobe_out,   // memory write strobe
  output logic                             prog_fetch_out,  // program word fetch active
  output logic                             queue_adv_out,   // queue advance pulse
  output logic [15:0]                      bus_addr_out     // bus address
);
  initial
  begin
    if (EXTRA_W < 1 || EXTRA_W > 8)
    begin
      $error("EXTRA_W out of range");
    end
  end

  typedef struct packed {
    bus_cycle_pkg::phase_t       ph;
    bus_cycle_pkg::access_kind_t kind;
    logic [EXTRA_W+1:0]          cnt;
    logic [1:0]                  fetches;
    logic                        rd;
    logic                        wr;
    logic                        pf;
    logic                        adv;
    logic                        done;
    logic                        taken;
    logic                        pre_mis;
    logic [15:0]                 addr;
    logic [15:0]                 tgt;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic               sz_word;
  logic               sz_mis;
  logic [EXTRA_W+1:0] sz_cycles;
  logic [15:0]        req_addr;

  word_access_sizer #(
    .EXTRA_W (EXTRA_W)
  ) u_sizer (
    .is_word_in    (sz_word),
    .narrow_ext_in (narrow_bus_in && external_in),
    .misaligned_in (sz_mis),
    .mis_ok_in     (mis_ok_in),
    .slow_cs_in    (slow_cs_in),
    .slow_extra_in (slow_extra_in),
    .cycles_out    (sz_cycles)
  );

  // sizing follows the live request in idle, the held access otherwise
  always_comb
  begin
    bus_cycle_pkg::access_kind_t k;
    k = (st_r.ph == bus_cycle_pkg::PH_IDLE) ? kind_in : st_r.kind;
    req_addr = (st_r.ph == bus_cycle_pkg::PH_IDLE) ? addr_in : st_r.addr;
    sz_word = (k != bus_cycle_pkg::ACC_CREAD8) && (k != bus_cycle_pkg::ACC_CWRITE8);
    // vectors and program words are always aligned
    sz_mis = req_addr[0] && (k != bus_cycle_pkg::ACC_VECTOR) && (k != bus_cycle_pkg::ACC_PROG_FETCH)
             && (k != bus_cycle_pkg::ACC_SHORT_BR) && (k != bus_cycle_pkg::ACC_LONG_BR);
  end

  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.adv  = 1'b0;
    st_nxt.done = 1'b0;
    unique case (st_r.ph)
      bus_cycle_pkg::PH_IDLE:
      begin
        st_nxt.rd = 1'b0;
        st_nxt.wr = 1'b0;
        st_nxt.pf = 1'b0;
        if (start_in)
        begin
          st_nxt.kind  = kind_in;
          st_nxt.addr  = addr_in;
          st_nxt.tgt   = {target_in[15:1], 1'b0};
          st_nxt.taken = taken_in;
          st_nxt.pre_mis = addr_in[0];
          st_nxt.cnt   = sz_cycles;
          unique case (kind_in)
            bus_cycle_pkg::ACC_UNSTACK16, bus_cycle_pkg::ACC_VECTOR:
            begin
              st_nxt.ph = bus_cycle_pkg::PH_MEM;
              st_nxt.rd = 1'b1;
              if (kind_in == bus_cycle_pkg::ACC_VECTOR)
              begin
                st_nxt.addr = {addr_in[15:1], 1'b0};
              end
            end
            bus_cycle_pkg::ACC_CREAD8, bus_cycle_pkg::ACC_CREAD16, bus_cycle_pkg::ACC_CWRITE8:
            begin
              if (do_access_in)
              begin
                st_nxt.ph = bus_cycle_pkg::PH_MEM;
                st_nxt.rd = (kind_in != bus_cycle_pkg::ACC_CWRITE8);
                st_nxt.wr = (kind_in == bus_cycle_pkg::ACC_CWRITE8);
              end
              else
              begin
                st_nxt.ph = bus_cycle_pkg::PH_FREE;
              end
            end
            bus_cycle_pkg::ACC_PROG_FETCH:
            begin
              st_nxt.ph   = bus_cycle_pkg::PH_MEM;
              st_nxt.pf   = 1'b1;
              st_nxt.addr = {addr_in[15:1], 1'b0};
            end
            bus_cycle_pkg::ACC_SHORT_BR:
            begin
              if (taken_in)
              begin
                // target is resolved at take, so the first fetch starts at once
                st_nxt.ph      = bus_cycle_pkg::PH_REFILL;
                st_nxt.addr    = {target_in[15:1], 1'b0};
                st_nxt.pf      = 1'b1;
                st_nxt.adv     = 1'b1;
                st_nxt.fetches = bus_cycle_pkg::REFILL_FETCHES - 2'h1;
              end
              else
              begin
                st_nxt.ph   = bus_cycle_pkg::PH_MEM;
                st_nxt.pf   = 1'b1;
                st_nxt.adv  = 1'b1;
                st_nxt.addr = {addr_in[15:1], 1'b0};
              end
            end
            bus_cycle_pkg::ACC_LONG_BR:
            begin
              st_nxt.ph = bus_cycle_pkg::PH_PREBYTE;
              st_nxt.pf = addr_in[0];
              st_nxt.addr = {addr_in[15:1], 1'b0};
              st_nxt.cnt = addr_in[0] ? sz_cycles : (EXTRA_W+2)'(1);
            end
            default:
            begin
              st_nxt.ph = bus_cycle_pkg::PH_IDLE;
            end
          endcase
        end
      end
      bus_cycle_pkg::PH_MEM, bus_cycle_pkg::PH_PREBYTE, bus_cycle_pkg::PH_REFILL, bus_cycle_pkg::PH_TRAIL:
      begin
        if (st_r.cnt > (EXTRA_W+2)'(1))
        begin
          st_nxt.cnt = st_r.cnt - (EXTRA_W+2)'(1);
        end
        else if (st_r.ph == bus_cycle_pkg::PH_PREBYTE)
        begin
          // taken: refill from target; not taken: one fetch before the trailing cycle
          st_nxt.ph  = bus_cycle_pkg::PH_REFILL;
          st_nxt.pf  = 1'b1;
          st_nxt.adv = 1'b1;
          st_nxt.cnt = sz_cycles;
          if (st_r.taken)
          begin
            st_nxt.addr    = st_r.tgt;
            st_nxt.fetches = bus_cycle_pkg::REFILL_FETCHES - 2'h1;
          end
          else
          begin
            st_nxt.addr    = st_r.addr + 16'h0002;
            st_nxt.fetches = 2'h0;
          end
        end
        else if (st_r.ph == bus_cycle_pkg::PH_REFILL && st_r.fetches != 2'h0)
        begin
          st_nxt.fetches = st_r.fetches - 2'h1;
          st_nxt.addr    = st_r.addr + 16'h0002;
          st_nxt.cnt     = sz_cycles;
          st_nxt.adv     = 1'b1;
        end
        else if (st_r.ph == bus_cycle_pkg::PH_REFILL && !st_r.taken)
        begin
          // trailing optional cycle is the opposite of the prebyte one
          st_nxt.ph   = bus_cycle_pkg::PH_TRAIL;
          st_nxt.pf   = !st_r.pre_mis;
          st_nxt.adv  = !st_r.pre_mis;
          st_nxt.addr = st_r.addr + 16'h0002;
          st_nxt.cnt  = st_r.pre_mis ? (EXTRA_W+2)'(1) : sz_cycles;
        end
        else
        begin
          st_nxt.ph   = bus_cycle_pkg::PH_IDLE;
          st_nxt.rd   = 1'b0;
          st_nxt.wr   = 1'b0;
          st_nxt.pf   = 1'b0;
          st_nxt.done = 1'b1;
        end
      end
      bus_cycle_pkg::PH_FREE:
      begin
        st_nxt.ph   = bus_cycle_pkg::PH_IDLE;
        st_nxt.done = 1'b1;
      end
      default:
      begin
        st_nxt.ph = bus_cycle_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign ready_out      = (st_r.ph == bus_cycle_pkg::PH_IDLE);
  assign done_out       = st_r.done;
  assign rd_strobe_out  = st_r.rd;
  assign wr_strobe_out  = st_r.wr;
  assign prog_fetch_out = st_r.pf;
  assign queue_adv_out  = st_r.adv;
  assign bus_addr_out   = st_r.addr;
endmodule : bus_cycle_seq

// File: bench/mem_model.sv
`timescale 1ns/100ps
// far-side memory: counts strobe cycles of each access
module mem_model (
  input  wire logic       sys_clk_in,    // clock
  input  wire logic       rst_n_in,      // reset, active low
  input  wire logic       clr_in,        // clear counts
  input  wire logic       rd_strobe_in,  // read strobe
  input  wire logic       wr_strobe_in,  // write strobe
  output logic      [7:0] rd_cnt_out,    // read cycles seen
  output logic      [7:0] wr_cnt_out     // write cycles seen
);
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_cnt_out <= 8'h00;
      wr_cnt_out <= 8'h00;
    end
    else if (clr_in)
    begin
      rd_cnt_out <= 8'h00;
      wr_cnt_out <= 8'h00;
    end
    else
    begin
      rd_cnt_out <= rd_cnt_out + {7'h00, rd_strobe_in};
      wr_cnt_out <= wr_cnt_out + {7'h00, wr_strobe_in};
    end
  end
endmodule : mem_model

// File: bench/bus_cycle_checker.sv
`timescale 1ns/100ps
module bus_cycle_checker #(
  parameter int EXTRA_W = 4
) (
  input wire logic                        sys_clk_in,     // clock
  input wire logic                        rst_n_in,       // reset
  input wire logic                        start_in,       // request
  input wire bus_cycle_pkg::access_kind_t kind_in,        // kind
  input wire logic [15:0]                 addr_in,        // address
  input wire logic                        do_access_in,   // do access
  input wire logic                        taken_in,       // taken
  input wire logic                        narrow_bus_in,  // 8-bit bus
  input wire logic                        external_in,    // external
  input wire logic                        mis_ok_in,      // misaligned ok
  input wire logic                        slow_cs_in,     // slow
  input wire logic                        ready_out,      // ready
  input wire logic                        done_out,       // done
  input wire logic                        rd_strobe_out,  // read
  input wire logic                        wr_strobe_out,  // write
  input wire logic                        prog_fetch_out, // fetch
  input wire logic                        queue_adv_out,  // queue advance
  input wire logic [15:0]                 bus_addr_out    // address
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire take = ready_out && start_in;
  wire fast = !slow_cs_in && !(narrow_bus_in && external_in);
  sequence s_refill;
    prog_fetch_out [*3] ##1 done_out;
  endsequence
  sequence s_rd2;
    rd_strobe_out [*2] ##1 done_out;
  endsequence
  a_free_cycle: assert property (take && kind_in == bus_cycle_pkg::ACC_CREAD8 && !do_access_in
    |=> !rd_strobe_out && !wr_strobe_out ##1 done_out) else $error("free cycle wrong");
  a_short_nt: assert property (take && kind_in == bus_cycle_pkg::ACC_SHORT_BR && !taken_in && fast
    |=> prog_fetch_out && queue_adv_out ##1 done_out) else $error("short not taken wrong");
  a_short_refill: assert property (take && kind_in == bus_cycle_pkg::ACC_SHORT_BR && taken_in && fast
    |=> s_refill) else $error("short taken wrong");
  a_long_taken: assert property (take && kind_in == bus_cycle_pkg::ACC_LONG_BR && taken_in && fast
    && !addr_in[0] |=> !prog_fetch_out ##1 s_refill) else $error("long taken wrong");
  a_long_nt: assert property (take && kind_in == bus_cycle_pkg::ACC_LONG_BR && !taken_in && fast
    && addr_in[0] |=> prog_fetch_out [*2] ##1 !prog_fetch_out ##1 done_out) else $error("long not taken wrong");
  a_unstack_one: assert property (take && kind_in == bus_cycle_pkg::ACC_UNSTACK16 && fast && !addr_in[0]
    |=> rd_strobe_out ##1 done_out) else $error("unstack length wrong");
  a_vector_two: assert property (take && kind_in == bus_cycle_pkg::ACC_VECTOR && !fast && !slow_cs_in
    |=> s_rd2) else $error("vector length wrong");
  a_cread_mis: assert property (take && kind_in == bus_cycle_pkg::ACC_CREAD16 && do_access_in && fast
    && addr_in[0] && !mis_ok_in |=> s_rd2) else $error("misaligned read wrong");
  a_write_one: assert property (take && kind_in == bus_cycle_pkg::ACC_CWRITE8 && do_access_in && !slow_cs_in
    |=> wr_strobe_out && !rd_strobe_out ##1 done_out) else $error("write length wrong");
  a_fetch_align: assert property (prog_fetch_out |-> !bus_addr_out[0]) else $error("odd fetch");
endmodule : bus_cycle_checker
bind bus_cycle_seq bus_cycle_checker #(.EXTRA_W(EXTRA_W)) chk_i (.sys_clk_in, .rst_n_in, .start_in, .kind_in,
  .addr_in, .do_access_in, .taken_in, .narrow_bus_in, .external_in, .mis_ok_in, .slow_cs_in, .ready_out,
  .done_out, .rd_strobe_out, .wr_strobe_out, .prog_fetch_out, .queue_adv_out, .bus_addr_out);

// File: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  bus_cycle_pkg::access_kind_t kind_in = bus_cycle_pkg::ACC_UNSTACK16;
  logic [15:0] addr_in = 16'h0000, target_in = 16'h0000, bus_addr_out;
  logic sys_clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, do_access_in = 1'b0, taken_in = 1'b0;
  logic narrow_bus_in = 1'b0, external_in = 1'b0, mis_ok_in = 1'b0, slow_cs_in = 1'b0, clr = 1'b0;
  logic [3:0] slow_extra_in = 4'h0;
  logic ready_out, done_out, rd_strobe_out, wr_strobe_out, prog_fetch_out, queue_adv_out, odd;
  logic [7:0] rd_cnt, wr_cnt, cyc, pf, adv;
  int error_cnt = 0, comparisons = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  bus_cycle_seq uut (.sys_clk_in, .rst_n_in, .start_in, .kind_in, .addr_in, .target_in, .do_access_in,
    .taken_in, .narrow_bus_in, .external_in, .mis_ok_in, .slow_cs_in, .slow_extra_in, .ready_out, .done_out,
    .rd_strobe_out, .wr_strobe_out, .prog_fetch_out, .queue_adv_out, .bus_addr_out);
  mem_model mem (.sys_clk_in, .rst_n_in, .clr_in(clr), .rd_strobe_in(rd_strobe_out),
    .wr_strobe_in(wr_strobe_out), .rd_cnt_out(rd_cnt), .wr_cnt_out(wr_cnt));
  task close_out;
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %0d expected %0d", $time, got, exp);
    end
  endtask : chk
  // flags: do_access, taken, narrow external, mis_ok, slow
  task op(input bus_cycle_pkg::access_kind_t k, input logic [15:0] a, input logic [4:0] f, input logic [3:0] x);
    kind_in = k;
    addr_in = a;
    target_in = a + 16'h0041;  // odd on purpose for even a, low bit must be ignored
    {do_access_in, taken_in, narrow_bus_in, mis_ok_in, slow_cs_in} = f;
    external_in = f[2];
    slow_extra_in = x;
    clr = 1'b1;
    start_in = 1'b1;
    @(posedge sys_clk_in);
    #1 start_in = 1'b0;
    clr = 1'b0;
    {pf, adv, odd} = '0;
    // outputs are looked at 1 ns after each edge, once settled
    for (cyc = 8'h01; cyc < 8'h64; cyc++)
    begin
      if (done_out === 1'b1) break;
      pf += {7'h00, prog_fetch_out};
      adv += {7'h00, queue_adv_out};
      // odd fetch address, or ready while busy
      odd |= ready_out | ((prog_fetch_out | (rd_strobe_out & (k == bus_cycle_pkg::ACC_VECTOR))) & bus_addr_out[0]);
      @(posedge sys_clk_in);
      #1;
    end
    if (cyc == 8'h64)
    begin
      error_cnt++;
      $display("Error at %0t: sequence never finished", $time);
      close_out();
    end
  endtask : op
  task t_unstack;
    op(bus_cycle_pkg::ACC_UNSTACK16, 16'h1000, 5'h00, 4'h0); chk(rd_cnt, 8'h01);
    op(bus_cycle_pkg::ACC_UNSTACK16, 16'h1000, 5'h04, 4'h0); chk(rd_cnt, 8'h02);
    op(bus_cycle_pkg::ACC_UNSTACK16, 16'h1001, 5'h00, 4'h0); chk(rd_cnt, 8'h02);
    op(bus_cycle_pkg::ACC_UNSTACK16, 16'h1001, 5'h02, 4'h0); chk(rd_cnt, 8'h01);
    op(bus_cycle_pkg::ACC_UNSTACK16, 16'h1000, 5'h01, 4'h3); chk(rd_cnt, 8'h04);
  endtask : t_unstack
  task t_vector;
    op(bus_cycle_pkg::ACC_VECTOR, 16'hFFF7, 5'h04, 4'h0); chk(rd_cnt, 8'h02);
    chk({7'h00, odd}, 8'h00);
  endtask : t_vector
  task t_cond;
    op(bus_cycle_pkg::ACC_CREAD8, 16'h2000, 5'h01, 4'h3); chk(rd_cnt, 8'h00);
    chk(cyc, 8'h02);
    op(bus_cycle_pkg::ACC_CREAD8, 16'h2000, 5'h11, 4'h2); chk(rd_cnt, 8'h03);
    op(bus_cycle_pkg::ACC_CREAD16, 16'h2000, 5'h14, 4'h0); chk(rd_cnt, 8'h02);
    op(bus_cycle_pkg::ACC_CREAD16, 16'h2001, 5'h10, 4'h0); chk(rd_cnt, 8'h02);
    op(bus_cycle_pkg::ACC_CWRITE8, 16'h2000, 5'h10, 4'h0); chk(wr_cnt, 8'h01);
    op(bus_cycle_pkg::ACC_CWRITE8, 16'h2000, 5'h11, 4'h1); chk(wr_cnt, 8'h02);
    op(bus_cycle_pkg::ACC_CWRITE8, 16'h2000, 5'h05, 4'h2); chk(cyc, 8'h02);
  endtask : t_cond
  task t_short;
    op(bus_cycle_pkg::ACC_SHORT_BR, 16'h3000, 5'h00, 4'h0); chk(cyc, 8'h02);
    chk(adv, 8'h01);
    op(bus_cycle_pkg::ACC_SHORT_BR, 16'h3000, 5'h08, 4'h0); chk(cyc, 8'h04);
    chk(pf, 8'h03);
    op(bus_cycle_pkg::ACC_SHORT_BR, 16'h3000, 5'h0C, 4'h0); chk(pf, 8'h06);
  endtask : t_short
  task t_long;
    op(bus_cycle_pkg::ACC_LONG_BR, 16'h4000, 5'h08, 4'h0); chk(pf, 8'h03);
    chk(cyc, 8'h05);
    op(bus_cycle_pkg::ACC_LONG_BR, 16'h4001, 5'h08, 4'h0); chk(pf, 8'h04);
    chk(cyc, 8'h05);
    op(bus_cycle_pkg::ACC_LONG_BR, 16'h4000, 5'h00, 4'h0); chk(pf, 8'h02);
    chk(cyc, 8'h04);
    chk({7'h00, odd}, 8'h00);
    op(bus_cycle_pkg::ACC_LONG_BR, 16'h4001, 5'h00, 4'h0); chk(pf, 8'h02);
    chk(cyc, 8'h04);
  endtask : t_long
  task t_fetch;
    op(bus_cycle_pkg::ACC_PROG_FETCH, 16'h5001, 5'h04, 4'h0); chk(pf, 8'h02);
    chk(cyc, 8'h03);
    chk({7'h00, odd}, 8'h00);
  endtask : t_fetch
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    t_unstack();
    t_vector();
    t_cond();
    t_short();
    t_long();
    t_fetch();
    close_out();
  end
endmodule : tb_top
